//--- verilog/qdsl_pkg.sv
// Purpose: Shared constants of the quad converter serial loader
// Assumes: 16-bit serial words, four 12-bit channels, AHB-Lite register port
// Notes: Offsets are byte addresses within the slave window
package qdsl_pkg;
    // Serial word layout
    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    localparam int DATA_LSB = 4;
    localparam int ADDR_HI_BIT = 3;
    localparam int ADDR_LO_BIT = 2;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam int CH_N = 4;
    localparam logic [3:0] LAST_BIT_CNT = 4'hf;
    // Channel code split
    localparam int SEG_W = 3;
    localparam int LADDER_W = 10;
    localparam int SEG_LSB = 10;
    // Register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INPUT_BASE = 8'h10;
    localparam logic [7:0] OFS_CONV_BASE = 8'h20;
    localparam int CTRL_CHECK_BIT = 0;
    localparam int CTRL_LOAD_BIT = 1;
    localparam int CTRL_CLEAR_BIT = 2;
    localparam logic CTRL_CHECK_RST = 1'h1;
    localparam int CNT_W = 8;
    localparam int STAT_ACC_LSB = 0;
    localparam int STAT_REJ_LSB = 8;
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage

//--- verilog/qdsl_chan_decode.sv
// Purpose: Splits one channel code into segment and ladder switch drives
// Assumes: Code is straight unsigned binary
// Notes: Outputs are registered, one cycle after the code
`timescale 1ns/100ps
`default_nettype none
module qdsl_chan_decode (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [qdsl_pkg::DATA_W-1:0] code,
    output logic [qdsl_pkg::SEG_W-1:0] seg_switch,
    output logic [qdsl_pkg::LADDER_W-1:0] ladder_switch
);
    import qdsl_pkg::*;

    typedef struct packed {
        logic [SEG_W-1:0] seg;
        logic [LADDER_W-1:0] ladder;
    } qdsl_dec_t;

    qdsl_dec_t dec_reg;
    qdsl_dec_t dec_next;
    logic [1:0] top_bits;

    assign top_bits = code[SEG_LSB +: 2];

    always_comb begin
        dec_next.ladder = code[LADDER_W-1:0];
        for (int k = 0; k < SEG_W; k++) begin
            dec_next.seg[k] = (top_bits > 2'(k));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_reg <= '0;
        end else begin
            dec_reg <= dec_next;
        end
    end

    assign seg_switch = dec_reg.seg;
    assign ladder_switch = dec_reg.ladder;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_ladder;
        ##1 ladder_switch == $past(code[LADDER_W-1:0]);
    endproperty
    a_ladder: assert property (p_ladder) else $error("ladder bits differ");

    property p_thermo;
        ##1 $countones(seg_switch) == $past(32'(top_bits))
            && (!seg_switch[2] || seg_switch[1]) && (!seg_switch[1] || seg_switch[0]);
    endproperty
    a_thermo: assert property (p_thermo) else $error("segment code wrong");
endmodule
`default_nettype wire

//--- verilog/qdsl_loader.sv
// Purpose: Serial input logic of a quad 12-bit converter with AHB-Lite view
// Assumes: Link logic runs on falling edges of serial_clock_in
// Notes: Load and clear pins pass a two-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Shift serial data in on each falling serial clock edge during a frame.
// - Serial output comes straight from the last shift register stage.
// - After sixteen bits, compare address bits with pins; accept or discard.
// - Accepted word's low two bits pick the input latch for its data.
// - Load low copies all four input latches to converter latches together, unless clear is also low.
// - Clear low forces all four converter latches to zero.
// - Clear never touches the input latches.
// - Two top code bits drive segments, ten low bits drive the ladder.
// - Codes are plain unsigned binary, zero up to 4095/4096 full scale.
// - Word holds twelve data bits first, then A1, A0, then select.
// - Select 00 is A, 01 B, 10 C, 11 D.
module qdsl_loader (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serial_clock_in,
    input wire logic frame_sync_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    input wire logic device_addr_bit0,
    input wire logic device_addr_bit1,
    input wire logic load_outputs_n,
    input wire logic clear_outputs_n,
    output logic [qdsl_pkg::CH_N-1:0][qdsl_pkg::DATA_W-1:0] conv_code,
    output logic [qdsl_pkg::CH_N-1:0][qdsl_pkg::SEG_W-1:0] seg_switch,
    output logic [qdsl_pkg::CH_N-1:0][qdsl_pkg::LADDER_W-1:0] ladder_switch
);
    import qdsl_pkg::*;

    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic [WORD_W-1:0] word;
        logic tgl;
    } qdsl_link_t;

    typedef struct packed {
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [1:0] tgl_s;
        logic tgl_d;
        logic evt;
        logic [WORD_W-1:0] word;
        logic chk_en;
        logic soft_ld;
        logic soft_clr;
        logic [CH_N-1:0][DATA_W-1:0] in_l;
        logic [CH_N-1:0][DATA_W-1:0] dac_l;
        logic [CNT_W-1:0] acc_cnt;
        logic [CNT_W-1:0] rej_cnt;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } qdsl_ref_t;

    // Pin order in the synchroniser
    localparam int PIN_A0 = 0;
    localparam int PIN_A1 = 1;
    localparam int PIN_LD = 2;
    localparam int PIN_CLR = 3;

    qdsl_link_t link_reg;
    qdsl_link_t link_next;
    qdsl_ref_t ref_reg;
    qdsl_ref_t ref_next;
    logic addr_hit;
    logic clr_act;
    logic ld_act;
    logic ahb_take;
    logic [WORD_W-1:0] shifted;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: shift register and word hand-off
    assign shifted = {link_reg.shift[WORD_W-2:0], serial_data_in};

    always_comb begin
        link_next = link_reg;
        bit_cnt_next = bit_cnt_reg;
        if (!frame_sync_n) begin
            link_next.shift = shifted;
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == LAST_BIT_CNT) begin
                // Word stays put until the next sixteen bits arrive
                link_next.word = shifted;
                link_next.tgl = ~link_reg.tgl;
            end
        end
    end

    always_ff @(negedge serial_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // Frame end clears the count at once; the host may stop its clock between frames
    always_ff @(negedge serial_clock_in or negedge rst_n or posedge frame_sync_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= '0;
        end else if (frame_sync_n) begin
            bit_cnt_reg <= '0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    assign serial_data_out = link_reg.shift[WORD_W-1];

    ////////////////////////////////////////////////////////////////////////
    // Reference domain: word check, latches, bus slave
    assign addr_hit = !ref_reg.chk_en
        || (ref_reg.word[ADDR_HI_BIT] == ref_reg.pin_s2[PIN_A1]
        && ref_reg.word[ADDR_LO_BIT] == ref_reg.pin_s2[PIN_A0]);
    assign clr_act = !ref_reg.pin_s2[PIN_CLR] || ref_reg.soft_clr;
    assign ld_act = !ref_reg.pin_s2[PIN_LD] || ref_reg.soft_ld;
    assign ahb_take = hsel && (htrans == HTRANS_NONSEQ) && hready;

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] v;
        v = '0;
        if (a == OFS_CTRL) begin
            v[CTRL_CHECK_BIT] = ref_reg.chk_en;
        end else if (a == OFS_STATUS) begin
            v[STAT_ACC_LSB +: CNT_W] = ref_reg.acc_cnt;
            v[STAT_REJ_LSB +: CNT_W] = ref_reg.rej_cnt;
        end else begin
            for (int i = 0; i < CH_N; i++) begin
                if (a == OFS_INPUT_BASE + 8'(4 * i)) begin
                    v[DATA_W-1:0] = ref_reg.in_l[i];
                end
                if (a == OFS_CONV_BASE + 8'(4 * i)) begin
                    v[DATA_W-1:0] = ref_reg.dac_l[i];
                end
            end
        end
        return v;
    endfunction

    always_comb begin
        ref_next = ref_reg;
        ref_next.pin_s1 = {clear_outputs_n, load_outputs_n, device_addr_bit1, device_addr_bit0};
        ref_next.pin_s2 = ref_reg.pin_s1;
        ref_next.tgl_s = {ref_reg.tgl_s[0], link_reg.tgl};
        ref_next.tgl_d = ref_reg.tgl_s[1];
        ref_next.evt = ref_reg.tgl_s[1] ^ ref_reg.tgl_d;
        if (ref_reg.tgl_s[1] ^ ref_reg.tgl_d) begin
            // Link word has been stable for at least two edges here
            ref_next.word = link_reg.word;
        end
        ref_next.soft_ld = 1'h0;
        ref_next.soft_clr = 1'h0;
        if (ref_reg.evt) begin
            if (addr_hit) begin
                ref_next.in_l[ref_reg.word[SEL_LSB +: SEL_W]] =
                    ref_reg.word[DATA_LSB +: DATA_W];
                ref_next.acc_cnt = ref_reg.acc_cnt + CNT_W'(1);
            end else begin
                ref_next.rej_cnt = ref_reg.rej_cnt + CNT_W'(1);
            end
        end
        if (clr_act) begin
            ref_next.dac_l = '0;
        end else if (ld_act) begin
            ref_next.dac_l = ref_reg.in_l;
        end
        ref_next.wr_pend = 1'h0;
        if (ref_reg.wr_pend && ref_reg.wr_addr == OFS_CTRL) begin
            ref_next.chk_en = hwdata[CTRL_CHECK_BIT];
            ref_next.soft_ld = hwdata[CTRL_LOAD_BIT];
            ref_next.soft_clr = hwdata[CTRL_CLEAR_BIT];
        end
        if (ahb_take) begin
            ref_next.wr_pend = hwrite && (hsize == HSIZE_WORD);
            ref_next.wr_addr = haddr[7:0];
            ref_next.rdata = hwrite ? 32'h0 : rd_word(haddr[7:0]);
        end
        ref_next.ready = 1'h1;
        ref_next.resp = HRESP_OKAY;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_reg <= '0;
            ref_reg.pin_s1 <= 4'hc;
            ref_reg.pin_s2 <= 4'hc;
            ref_reg.chk_en <= CTRL_CHECK_RST;
            ref_reg.ready <= 1'h1;
        end else begin
            ref_reg <= ref_next;
        end
    end

    assign hreadyout = ref_reg.ready;
    assign hresp = ref_reg.resp;
    assign hrdata = ref_reg.rdata;
    assign conv_code = ref_reg.dac_l;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel switch decoding
    for (genvar c = 0; c < CH_N; c++) begin : g_chan
        qdsl_chan_decode u_dec (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .code(ref_reg.dac_l[c]),
            .seg_switch(seg_switch[c]),
            .ladder_switch(ladder_switch[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the link side
    property p_shift_in;
        @(negedge serial_clock_in) disable iff (!rst_n)
        !frame_sync_n |=> link_reg.shift[0] == $past(serial_data_in);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("serial bit not taken");

    property p_chain_out;
        @(negedge serial_clock_in) disable iff (!rst_n)
        !frame_sync_n |=> serial_data_out == $past(link_reg.shift[WORD_W-2]);
    endproperty
    a_chain_out: assert property (p_chain_out) else $error("chain output wrong");

    property p_word_done;
        @(negedge serial_clock_in) disable iff (!rst_n)
        (!frame_sync_n && bit_cnt_reg == LAST_BIT_CNT)
            |=> link_reg.word == $past(shifted) && link_reg.tgl != $past(link_reg.tgl);
    endproperty
    a_word_done: assert property (p_word_done) else $error("word not handed over");

    property p_frame_start;
        @(negedge frame_sync_n) disable iff (!rst_n)
        bit_cnt_reg == 4'h0;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("stale bit count");

    // Checks on the reference side
    sequence s_word_ok;
        ref_reg.evt && addr_hit;
    endsequence

    sequence s_word_bad;
        ref_reg.evt && !addr_hit;
    endsequence

    sequence s_clr_pin_low;
        !clear_outputs_n [*3];
    endsequence

    property p_accept;
        @(posedge ref_clk) disable iff (!rst_n)
        s_word_ok |=> ref_reg.in_l[$past(ref_reg.word[SEL_LSB +: SEL_W])]
            == $past(ref_reg.word[DATA_LSB +: DATA_W]);
    endproperty
    a_accept: assert property (p_accept) else $error("accepted word not latched");

    property p_reject;
        @(posedge ref_clk) disable iff (!rst_n)
        s_word_bad |=> $stable(ref_reg.in_l) && ref_reg.rej_cnt != $past(ref_reg.rej_cnt);
    endproperty
    a_reject: assert property (p_reject) else $error("foreign word latched");

    property p_load;
        @(posedge ref_clk) disable iff (!rst_n)
        (ld_act && !clr_act) |=> conv_code == $past(ref_reg.in_l);
    endproperty
    a_load: assert property (p_load) else $error("load did not copy");

    property p_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        clr_act |=> conv_code == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero");

    property p_clear_keeps;
        @(posedge ref_clk) disable iff (!rst_n)
        (clr_act && !ref_reg.evt) |=> $stable(ref_reg.in_l);
    endproperty
    a_clear_keeps: assert property (p_clear_keeps) else $error("clear hit inputs");

    property p_clear_pin;
        @(posedge ref_clk) disable iff (!rst_n)
        s_clr_pin_low |=> conv_code == '0;
    endproperty
    a_clear_pin: assert property (p_clear_pin) else $error("clear pin ignored");

    sequence s_ld_pin_low;
        (!load_outputs_n && clear_outputs_n) [*3] ##0 !ref_reg.soft_clr;
    endsequence

    sequence s_ctrl_wr;
        ref_reg.wr_pend && ref_reg.wr_addr == OFS_CTRL;
    endsequence

    property p_load_pin;
        @(posedge ref_clk) disable iff (!rst_n)
        s_ld_pin_low |=> conv_code == $past(ref_reg.in_l);
    endproperty
    a_load_pin: assert property (p_load_pin) else $error("load pin ignored");

    property p_soft_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        s_ctrl_wr ##0 hwdata[CTRL_CLEAR_BIT] |-> ##2 conv_code == '0;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft clear ignored");

    property p_soft_load;
        @(posedge ref_clk) disable iff (!rst_n)
        s_ctrl_wr ##0 hwdata[CTRL_LOAD_BIT] ##1 !clr_act |=> conv_code == $past(ref_reg.in_l);
    endproperty
    a_soft_load: assert property (p_soft_load) else $error("soft load ignored");

    property p_acc_count;
        @(posedge ref_clk) disable iff (!rst_n)
        s_word_ok |=> ref_reg.acc_cnt == $past(ref_reg.acc_cnt) + CNT_W'(1);
    endproperty
    a_acc_count: assert property (p_acc_count) else $error("accept count wrong");

    property p_in_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        !ref_reg.evt |=> $stable(ref_reg.in_l);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("input latch moved");
endmodule
`default_nettype wire

//--- testbench/qdsl_host_model.sv
// Purpose: Host serial port model driving the converter link
// Assumes: Link clock idles high with a 30 ns period, stopped between frames
// Notes: Data changes while the clock is high and is sampled on its fall
`timescale 1ns/100ps
`default_nettype none
module qdsl_host_model (
    output logic serial_clock_in,
    output logic frame_sync_n,
    output logic serial_data_in
);
    initial begin
        serial_clock_in = 1'b1;
        frame_sync_n = 1'b1;
        serial_data_in = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Sends the top n bits of w, most significant first
    task automatic send_word(input logic [15:0] w, input int n);
        int i;
        #7;
        frame_sync_n = 1'b0;
        for (i = 15; i > 15 - n; i--) begin
            serial_data_in = w[i];
            #15 serial_clock_in = 1'b0;
            #15 serial_clock_in = 1'b1;
        end
        #15 frame_sync_n = 1'b1;
        // Released line shows the inverse of the last bit
        serial_data_in = ~serial_data_in;
    endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the quad converter serial loader
// Assumes: Straps set to A1=1, A0=0; zero wait state register bus
// Notes: Each scenario task drives the block and judges its outputs
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import qdsl_pkg::*;
    logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, serial_data_out;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic serial_clock_in, frame_sync_n, serial_data_in;
    logic device_addr_bit0, device_addr_bit1, load_outputs_n, clear_outputs_n;
    logic [CH_N-1:0][DATA_W-1:0] conv_code;
    logic [CH_N-1:0][SEG_W-1:0] seg_switch;
    logic [CH_N-1:0][LADDER_W-1:0] ladder_switch;
    logic [11:0] codes [4] = '{12'hfff, 12'h800, 12'h400, 12'h001};
    int fail_count = 0;
    int samples_checked = 0;

    qdsl_host_model host (.serial_clock_in(serial_clock_in), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in));
    qdsl_loader dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .serial_clock_in(serial_clock_in), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .device_addr_bit0(device_addr_bit0), .device_addr_bit1(device_addr_bit1),
        .load_outputs_n(load_outputs_n), .clear_outputs_n(clear_outputs_n),
        .conv_code(conv_code), .seg_switch(seg_switch), .ladder_switch(ladder_switch));

    always #25 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %0t %s", $time, msg);
            fail_count++;
        end
    endtask

    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One single word transfer; read data taken at the data phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "bus response");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        bus(1'b0, OFS_CTRL, 32'h0, r);
        check(r, 32'h1, "control reset value");
        check({8'h0, conv_code[0], conv_code[3]}, 32'h0, "converter reset value");
    endtask

    task automatic t_latch();
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            host.send_word({codes[i], 2'b10, 2'(i)}, 16);
            repeat (10) @(posedge ref_clk);
            bus(1'b0, OFS_INPUT_BASE + 8'(4 * i), 32'h0, r);
            check(r, {20'h0, codes[i]}, "input latch");
            check({31'h0, serial_data_out}, {31'h0, codes[i][11]}, "chain out");
        end
        bus(1'b0, OFS_STATUS, 32'h0, r);
        check(r, 32'h4, "accepted count");
    endtask

    task automatic t_reject();
        logic [31:0] r;
        host.send_word({12'h5a5, 2'b01, 2'b00}, 16);
        host.send_word({12'h123, 2'b10, 2'b01}, 8);
        host.send_word({codes[1], 2'b10, 2'b01}, 16);
        repeat (10) @(posedge ref_clk);
        bus(1'b0, OFS_INPUT_BASE, 32'h0, r);
        check(r, 32'hfff, "wrong address kept out");
        bus(1'b0, OFS_INPUT_BASE + 8'h4, 32'h0, r);
        check(r, 32'h800, "partial word kept out");
        bus(1'b1, OFS_STATUS, 32'hffff, r);
        bus(1'b0, OFS_STATUS, 32'h0, r);
        check(r, 32'h105, "reject count, status read only");
        bus(1'b0, 8'h3c, 32'h0, r);
        check(r, 32'h0, "unmapped read");
    endtask

    task automatic t_load();
        logic [31:0] r;
        load_outputs_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            check({20'h0, conv_code[i]}, {20'h0, codes[i]}, "load all");
            check({29'h0, seg_switch[i]}, {29'h0, 3'((4'h1 << codes[i][11:10]) - 4'h1)},
                "segments");
            check({22'h0, ladder_switch[i]}, {22'h0, codes[i][9:0]}, "ladder");
        end
        load_outputs_n <= 1'b1;
        bus(1'b0, OFS_CONV_BASE + 8'hc, 32'h0, r);
        check(r, 32'h1, "converter latch read");
    endtask

    task automatic t_clear();
        logic [31:0] r;
        clear_outputs_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({31'h0, conv_code != '0}, 32'h0, "clear all");
        bus(1'b0, OFS_INPUT_BASE + 8'hc, 32'h0, r);
        check(r, 32'h1, "input latch kept");
        load_outputs_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({20'h0, conv_code[0]}, 32'h0, "clear beats load");
        clear_outputs_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check({20'h0, conv_code[0]}, 32'hfff, "codes restored");
        load_outputs_n <= 1'b1;
    endtask

    task automatic t_ctrl();
        logic [31:0] r;
        bus(1'b1, OFS_CTRL, 32'h0, r);
        host.send_word({12'h5a5, 2'b01, 2'b11}, 16);
        repeat (10) @(posedge ref_clk);
        bus(1'b0, OFS_INPUT_BASE + 8'hc, 32'h0, r);
        check(r, 32'h5a5, "check off accepts any address");
        host.send_word({codes[3], 2'b01, 2'b11}, 16);
        repeat (10) @(posedge ref_clk);
        bus(1'b0, OFS_STATUS, 32'h0, r);
        check(r, 32'h107, "accepted count, check off");
        bus(1'b1, OFS_CTRL, 32'h5, r);
        repeat (2) @(posedge ref_clk);
        check({31'h0, conv_code != '0}, 32'h0, "soft clear");
        bus(1'b0, OFS_CTRL, 32'h0, r);
        check(r, 32'h1, "soft bits read zero");
        bus(1'b1, OFS_CTRL, 32'h3, r);
        repeat (2) @(posedge ref_clk);
        check({20'h0, conv_code[3]}, {20'h0, codes[3]}, "soft load D");
        check({20'h0, conv_code[0]}, {20'h0, codes[0]}, "soft load A");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        device_addr_bit1 = 1'b1;
        device_addr_bit0 = 1'b0;
        load_outputs_n = 1'b1;
        clear_outputs_n = 1'b1;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_latch();
        t_reject();
        t_load();
        t_clear();
        t_ctrl();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
